// *** rtl/bert_rx_pkg.sv ***
// constants and types for the receive bit error rate monitor
package bert_rx_pkg;

  // ==========================================================
  // widths
  localparam int BC_W  = 32;
  localparam int EC_W  = 24;
  localparam int REG_W = 16;

  // ==========================================================
  // register byte offsets (low 12 address bits)
  localparam logic [11:0] CTRL_OFS = 12'h500;
  localparam logic [11:0] BC0_OFS  = 12'h510;
  localparam logic [11:0] BC1_OFS  = 12'h514;
  localparam logic [11:0] EC0_OFS  = 12'h518;
  localparam logic [11:0] EC1_OFS  = 12'h51C;

  // ==========================================================
  // monitor_control fields
  localparam int CTL_LATCH   = 0;
  localparam int CTL_PRBS    = 1;
  localparam int CTL_LEN_LSB = 8;
  localparam int CTL_LEN_W   = 4;
  localparam int CTL_OVF_IE  = 13;
  localparam int CTL_ERR_IE  = 14;
  localparam int CTL_CHG_IE  = 15;
  localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;

  // ==========================================================
  // error_count_low_and_status fields
  localparam int ST_SYNC   = 0;
  localparam int ST_EC_OVF = 1;
  localparam int ST_BC_OVF = 2;
  localparam int ST_ERR    = 3;
  localparam int ST_LOST   = 4;
  localparam int ST_ZEROS  = 5;
  localparam int ST_ONES   = 6;
  localparam int ST_CHG    = 7;
  localparam int ST_EC_LSB = 8;

  // ==========================================================
  // synchroniser figures
  localparam logic [5:0] SYNC_MATCH  = 6'h20;
  localparam int         LOSS_WIN    = 64;
  localparam logic [6:0] LOSS_ERRS   = 7'h06;
  localparam logic [4:0] RUN_LEN     = 5'h1F;
  localparam logic [4:0] REP_IDX_MIN = 5'h10;
  localparam int         PRBS_TAP_A  = 13;
  localparam int         PRBS_TAP_B  = 14;
  localparam logic [BC_W-1:0] BC_MAX = 32'hFFFFFFFF;
  localparam logic [EC_W-1:0] EC_MAX = 24'hFFFFFF;

  // ==========================================================
  // types
  typedef enum logic {
    SYNC_HUNT = 1'b0,
    SYNC_LOCK = 1'b1
  } sync_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic        valid;
  } ahb_req_t;

  typedef struct packed {
    logic chg;
    logic ones;
    logic zeros;
    logic lost;
    logic err;
    logic bc_full;
    logic ec_full;
  } flags_t;

endpackage

// *** rtl/bert_receive_monitor.sv ***
// receive bit error rate monitor with ahb-lite register slave
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - received-bit counter, 32 bits, advances once per received bit.
// - both counters keep counting while the monitor hunts for lock.
// - rising edge of count latch bit copies both counters to registers.
// - received-bit counter saturates at maximum and sets its overflow flag.
// - 24-bit errored-bit counter advances on every mismatching received bit.
// - errored-bit counter saturates at maximum and sets its overflow flag.
// - lock indicator rises after 32 consecutive matching bit positions.
// - lock indicator drops on 6 or more errors within 64 bits.
// - error overflow flag latches, clears on read, stays clear until next.
// - bit overflow flag latches, clears on read, stays clear until next.
// - bit error flag latches only while locked; read clears it.
// - lock lost flag latches on start of hunting; held until read.
// - all zeros flag latches after 31 zeros; clearable after a one.
// - all ones flag latches after 31 ones; clearable after a zero.
// - error count low byte in status bits 15:8, upper 16 elsewhere.
// - counter overflow interrupts only with overflow enable bit set.
// - bit error interrupts only with bit error enable bit set.
// - lock change interrupts only with lock change enable bit set.
module bert_receive_monitor (
  // clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // ahb-lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // monitored serial stream
  input  wire logic                      rx_clk,
  input  wire logic                      rx_data,
  // status
  output logic                           lock,
  output logic                           irq
);
  import bert_rx_pkg::*;

  // ==========================================================
  // address decode helper
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // link input synchronisers and bit strobe
  logic [2:0] clk_sync_r;
  logic [1:0] dat_sync_r;
  logic       bit_stb;
  logic       bit_val;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sync_r <= 3'h0;
      dat_sync_r <= 2'h0;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], rx_clk};
      dat_sync_r <= {dat_sync_r[0], rx_data};
    end
  end

  // rising edge of the link clock marks one received bit
  assign bit_stb = clk_sync_r[1] & ~clk_sync_r[2];
  assign bit_val = dat_sync_r[1];
  // the link clock must stay high and low for more than one bus
  // clock each, or bits are missed

  // ==========================================================
  // bus slave: address phase capture
  ahb_req_t         req_r;
  logic [REG_W-1:0] ctrl_r;
  logic             accept;
  logic             rd_stat;

  assign accept    = hsel & hready & htrans[1];
  assign rd_stat   = accept & ~hwrite & hit(haddr[11:0], EC0_OFS);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // zero wait states: a control read whose address phase is the write's
  // data phase still returns the old value

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= '0;
    end else begin
      req_r.addr  <= haddr[11:0];
      req_r.write <= hwrite;
      req_r.valid <= accept;
    end
  end

  // control register written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (req_r.valid && req_r.write && hit(req_r.addr, CTRL_OFS)) begin
      ctrl_r <= hwdata[REG_W-1:0];
    end
  end

  // ==========================================================
  // pattern reference and compare
  logic [BC_W-1:0] hist_r;
  logic [4:0]      rep_idx;
  logic            expect_bit;
  logic            bit_err;

  assign rep_idx = REP_IDX_MIN
                 + {1'b0, ctrl_r[CTL_LEN_LSB +: CTL_LEN_W]};
  // self-synchronising reference: prbs taps or the bit one period back
  assign expect_bit = ctrl_r[CTL_PRBS]
                    ? (hist_r[PRBS_TAP_A] ^ hist_r[PRBS_TAP_B])
                    : hist_r[rep_idx];
  assign bit_err = bit_stb & (bit_val != expect_bit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_r <= '0;
    end else if (bit_stb) begin
      hist_r <= {hist_r[BC_W-2:0], bit_val};
    end
  end

  // ==========================================================
  // synchroniser state
  sync_state_t         state_r;
  sync_state_t         state_nxt;
  logic [5:0]          match_r;
  logic [5:0]          match_nxt;
  logic [LOSS_WIN-1:0] win_r;
  logic [6:0]          win_cnt_r;
  logic [6:0]          win_cnt_nxt;
  logic                go_lock;
  logic                go_hunt;

  always_comb begin
    match_nxt   = match_r;
    win_cnt_nxt = win_cnt_r;
    state_nxt   = state_r;
    if (bit_stb) begin
      unique case (state_r)
        SYNC_HUNT: begin
          match_nxt = bit_err ? 6'h00 : match_r + 6'h01;
          if (match_nxt == SYNC_MATCH) begin
            state_nxt = SYNC_LOCK;
          end
        end
        SYNC_LOCK: begin
          win_cnt_nxt = win_cnt_r + {6'h00, bit_err}
                      - {6'h00, win_r[LOSS_WIN-1]};
          if (win_cnt_nxt >= LOSS_ERRS) begin
            state_nxt = SYNC_HUNT;
          end
        end
      endcase
    end
  end

  assign go_lock = (state_r == SYNC_HUNT) && (state_nxt == SYNC_LOCK);
  assign go_hunt = (state_r == SYNC_LOCK) && (state_nxt == SYNC_HUNT);

  // the loss window only runs while locked and restarts on every
  // change of lock state

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r   <= SYNC_HUNT;
      match_r   <= 6'h00;
      win_r     <= '0;
      win_cnt_r <= 7'h00;
    end else begin
      state_r <= state_nxt;
      if (go_lock || go_hunt) begin
        match_r   <= 6'h00;
        win_r     <= '0;
        win_cnt_r <= 7'h00;
      end else begin
        match_r   <= match_nxt;
        win_cnt_r <= win_cnt_nxt;
        if (bit_stb && state_r == SYNC_LOCK) begin
          win_r <= {win_r[LOSS_WIN-2:0], bit_err};
        end
      end
    end
  end

  assign lock = (state_r == SYNC_LOCK);

  // ==========================================================
  // bit and error counters
  logic [BC_W-1:0] bc_r;
  logic [EC_W-1:0] ec_r;
  logic            bc_ovf;
  logic            ec_ovf;

  // overflow flagged on the step onto the maximum; the counter
  // then stands there until reset
  // counting ignores lock state
  assign bc_ovf = bit_stb && (bc_r == BC_MAX - 32'h1);
  assign ec_ovf = bit_err && (ec_r == EC_MAX - 24'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bc_r <= '0;
    end else if (bit_stb && bc_r != BC_MAX) begin
      bc_r <= bc_r + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ec_r <= '0;
    end else if (bit_err && ec_r != EC_MAX) begin
      ec_r <= ec_r + 24'h1;
    end
  end

  // ==========================================================
  // count latch
  logic            latch_d_r;
  logic [BC_W-1:0] bc_cap_r;
  logic [EC_W-1:0] ec_cap_r;

  // host reads see the last capture, zero before the first one

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_d_r <= 1'b0;
      bc_cap_r  <= '0;
      ec_cap_r  <= '0;
    end else begin
      latch_d_r <= ctrl_r[CTL_LATCH];
      if (ctrl_r[CTL_LATCH] && !latch_d_r) begin
        bc_cap_r <= bc_r;
        ec_cap_r <= ec_r;
      end
    end
  end

  // ==========================================================
  // run detectors for all zeros and all ones
  logic [4:0] zrun_r;
  logic [4:0] orun_r;
  logic       zrun_hit;
  logic       orun_hit;
  logic       z_ok_r;
  logic       o_ok_r;

  assign zrun_hit = bit_stb & ~bit_val & (zrun_r == RUN_LEN - 5'h1);
  assign orun_hit = bit_stb & bit_val & (orun_r == RUN_LEN - 5'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zrun_r <= 5'h00;
      orun_r <= 5'h00;
    end else if (bit_stb) begin
      zrun_r <= bit_val ? 5'h00
              : (zrun_r == RUN_LEN) ? RUN_LEN : zrun_r + 5'h01;
      orun_r <= !bit_val ? 5'h00
              : (orun_r == RUN_LEN) ? RUN_LEN : orun_r + 5'h01;
    end
  end

  // clearing is allowed only after the opposite bit arrives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      z_ok_r <= 1'b0;
      o_ok_r <= 1'b0;
    end else begin
      if (zrun_hit) begin
        z_ok_r <= 1'b0;
      end else if (bit_stb && bit_val) begin
        z_ok_r <= 1'b1;
      end
      if (orun_hit) begin
        o_ok_r <= 1'b0;
      end else if (bit_stb && !bit_val) begin
        o_ok_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // latched flags, cleared by reading the status register
  flags_t flags_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= '0;
    end else begin
      // set takes priority over the read clear
      flags_r.ec_full <= ec_ovf | (flags_r.ec_full & ~rd_stat);
      flags_r.bc_full <= bc_ovf | (flags_r.bc_full & ~rd_stat);
      flags_r.err     <= (bit_err & lock)
                       | (flags_r.err & ~rd_stat);
      flags_r.lost    <= go_hunt | (flags_r.lost & ~rd_stat);
      flags_r.zeros   <= zrun_hit
                       | (flags_r.zeros & ~(rd_stat & z_ok_r));
      flags_r.ones    <= orun_hit
                       | (flags_r.ones & ~(rd_stat & o_ok_r));
      flags_r.chg     <= go_lock | go_hunt
                       | (flags_r.chg & ~rd_stat);
    end
  end

  // ==========================================================
  // interrupt
  logic irq_r;

  // registered: irq trails its flag or enable by one clock

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ((flags_r.ec_full | flags_r.bc_full)
                & ctrl_r[CTL_OVF_IE])
             | (flags_r.err & ctrl_r[CTL_ERR_IE])
             | (flags_r.chg & ctrl_r[CTL_CHG_IE]);
    end
  end

  assign irq = irq_r;

  // ==========================================================
  // read data, registered at the address phase
  logic [REG_W-1:0] stat_word;
  logic [REG_W-1:0] rd_val;

  always_comb begin
    stat_word = '0;
    stat_word[ST_SYNC]   = lock;
    stat_word[ST_EC_OVF] = flags_r.ec_full;
    stat_word[ST_BC_OVF] = flags_r.bc_full;
    stat_word[ST_ERR]    = flags_r.err;
    stat_word[ST_LOST]   = flags_r.lost;
    stat_word[ST_ZEROS]  = flags_r.zeros;
    stat_word[ST_ONES]   = flags_r.ones;
    stat_word[ST_CHG]    = flags_r.chg;
    stat_word[ST_EC_LSB +: 8] = ec_cap_r[7:0];
  end

  always_comb begin
    rd_val = '0;
    if (hit(haddr[11:0], CTRL_OFS)) begin
      rd_val = ctrl_r;
    end else if (hit(haddr[11:0], BC0_OFS)) begin
      rd_val = bc_cap_r[15:0];
    end else if (hit(haddr[11:0], BC1_OFS)) begin
      rd_val = bc_cap_r[31:16];
    end else if (hit(haddr[11:0], EC0_OFS)) begin
      rd_val = stat_word;
    end else if (hit(haddr[11:0], EC1_OFS)) begin
      rd_val = ec_cap_r[23:8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (accept && !hwrite) begin
      hrdata <= {16'h0000, rd_val};
    end
  end

endmodule // bert_receive_monitor

// *** verif/bert_receive_monitor_props.sv ***
// port-level assertion checker for the receive monitor
`timescale 1ns/1ps
module bert_rx_props (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // link and status
  input wire logic        rx_clk,
  input wire logic        rx_data,
  input wire logic        lock,
  input wire logic        irq
);
  import bert_rx_pkg::*;
  logic        rd_r;
  logic        wr_r;
  logic [11:0] a_r;
  logic [15:0] ctl_r;
  logic [7:0]  rxh_r;
  logic        mapped;
  logic        rx_rose;
  assign mapped  = a_r inside {CTRL_OFS, BC0_OFS, BC1_OFS, EC0_OFS, EC1_OFS};
  assign rx_rose = |(rxh_r[6:0] & ~rxh_r[7:1]);
  // ==========================================================
  // bus phase shadow and control copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      a_r   <= 12'h000;
      ctl_r <= 16'h0000;
      rxh_r <= 8'h00;
    end else begin
      rd_r  <= hsel & hready & htrans[1] & ~hwrite;
      wr_r  <= hsel & hready & htrans[1] & hwrite;
      a_r   <= haddr[11:0];
      rxh_r <= {rxh_r[6:0], rx_clk};
      if (wr_r && a_r == CTRL_OFS) begin
        ctl_r <= hwdata[15:0];
      end
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_UPPER_ZERO: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_HOLD: assert property (!rd_r |-> $stable(hrdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (rd_r && !mapped |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_BACK: assert property (
    rd_r && a_r == CTRL_OFS |->
    ((hrdata[15:0] ^ $past(ctl_r)) & 16'hEF03) == 16'h0000)
    else $error("control readback differs");
  AST_SYNC_BIT: assert property (
    rd_r && a_r == EC0_OFS |-> hrdata[ST_SYNC] == $past(lock))
    else $error("status lock bit differs from lock");
  AST_LOCK_TIMING: assert property ($changed(lock) |-> rx_rose)
    else $error("lock moved without a received bit");
  AST_IRQ_MASK: assert property (irq |-> $past(|ctl_r[15:13]))
    else $error("interrupt with all enables clear");
  AST_CHG_IRQ: assert property ($rose(lock) && ctl_r[15] |-> ##[1:2] irq)
    else $error("lock change gave no interrupt");
endmodule // bert_rx_props

bind bert_receive_monitor bert_rx_props u_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .rx_clk, .rx_data, .lock, .irq
);

// *** verif/bert_stream_src.sv ***
// serial stream source standing at the monitored link
`timescale 1ns/1ps
module bert_stream_src (
  // link out
  output logic rx_clk,
  output logic rx_data
);
  initial begin
    rx_clk  = 1'b0;
    rx_data = 1'b0;
  end
  // one 160 ns bit; clock stands low between bits
  task automatic send_bit(input logic b);
    #1.3;
    rx_data = b;
    #37.4;
    rx_clk = 1'b1;
    #80;
    rx_clk = 1'b0;
    #40;
    rx_data = ~b;
    #1.3;
  endtask
endmodule // bert_stream_src

// *** verif/bert_receive_monitor_tb.sv ***
// self-checking bench for the receive monitor
`timescale 1ns/1ps
module bert_receive_monitor_tb;
  import bert_rx_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        rx_clk;
  logic        rx_data;
  logic        lock;
  logic        irq;
  logic [15:0] ctl;
  logic [16:0] pat;
  int          idx;
  int          cyc = 0;
  int          n_mismatch;
  int          total_checks;
  assign hready = hreadyout;
  bert_receive_monitor u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .rx_clk, .rx_data, .lock, .irq
  );
  bert_stream_src u_src (.rx_clk, .rx_data);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ==========================================================
  // shared tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // latch both counters, then read them and the status word
  task automatic snap(output logic [31:0] bc, output logic [23:0] ec,
                      output logic [15:0] st);
    logic [31:0] lo, hi, s, eh;
    bus(1'b1, CTRL_OFS, {16'h0000, ctl}, lo);
    bus(1'b1, CTRL_OFS, {16'h0000, ctl | 16'h0001}, lo);
    bus(1'b0, BC0_OFS, 32'h0, lo);
    bus(1'b0, BC1_OFS, 32'h0, hi);
    bus(1'b0, EC0_OFS, 32'h0, s);
    bus(1'b0, EC1_OFS, 32'h0, eh);
    bc = {hi[15:0], lo[15:0]};
    ec = {eh[15:0], s[15:8]};
    st = s[15:0];
  endtask
  // repetitive 17-bit pattern with up to three flipped bits
  task automatic pbits(input int n, input int f0, input int f1, input int f2);
    for (int i = 0; i < n; i++) begin
      u_src.send_bit(pat[idx % 17] ^ (i == f0 || i == f1 || i == f2));
      idx++;
    end
    repeat (8) @(posedge hclk);
  endtask
  task automatic run(input logic b, input int n, input int k, input logic e);
    logic [31:0] bc;
    logic [23:0] ec;
    logic [15:0] st;
    repeat (n) u_src.send_bit(b);
    repeat (8) @(posedge hclk);
    snap(bc, ec, st);
    chk({31'h0, st[k]}, {31'h0, e});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic [11:0] al [6];
    al = '{CTRL_OFS, BC0_OFS, BC1_OFS, EC0_OFS, EC1_OFS, 12'h600};
    bus(1'b1, EC1_OFS, 32'h0000FFFF, q);
    bus(1'b1, BC0_OFS, 32'h0000FFFF, q);
    foreach (al[i]) begin
      bus(1'b0, al[i], 32'h0, q);
      chk(q, 32'h0);
    end
    chk({30'h0, lock, irq}, 32'h0);
  endtask
  task automatic t_lock();
    logic [31:0] q;
    logic [23:0] ec;
    logic [15:0] st;
    ctl = 16'h8000;
    bus(1'b1, CTRL_OFS, {16'h0000, ctl}, q);
    pbits(68, -1, -1, -1);
    chk({30'h0, lock, irq}, 32'h3);
    snap(q, ec, st);
    chk(q, 32'h00000044);
    chk({24'h0, st[7:0]}, 32'h81);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_error();
    logic [31:0] b0, b1, q;
    logic [23:0] e0, e1;
    logic [15:0] st;
    snap(b0, e0, st);
    pbits(34, 5, -1, -1);
    chk({30'h0, lock, irq}, 32'h2);
    ctl = 16'hC000;
    bus(1'b1, CTRL_OFS, {16'h0000, ctl}, q);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    snap(b1, e1, st);
    chk(b1 - b0, 32'h22);
    chk({8'h00, e1 - e0}, 32'h2);
    chk({24'h0, st[7:0]}, 32'h09);
    snap(b0, e0, st);
    chk(b0 - b1, 32'h0);
    chk({24'h0, st[7:0]}, 32'h01);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_loss();
    logic [31:0] b0, b1;
    logic [23:0] e0, e1;
    logic [15:0] st;
    snap(b0, e0, st);
    pbits(30, 2, 4, 6);
    chk({31'h0, lock}, 32'h0);
    pbits(60, -1, -1, -1);
    chk({31'h0, lock}, 32'h1);
    snap(b1, e1, st);
    chk(b1 - b0, 32'h5A);
    chk({8'h00, e1 - e0}, 32'h6);
    chk({24'h0, st[7:0]}, 32'h99);
    snap(b0, e0, st);
    chk({24'h0, st[7:0]}, 32'h01);
  endtask
  task automatic t_runs();
    for (int v = 0; v < 2; v++) begin
      u_src.send_bit(~v[0]);
      run(v[0], 30, ST_ZEROS + v, 1'b0);
      run(v[0], 1, ST_ZEROS + v, 1'b1);
      run(v[0], 0, ST_ZEROS + v, 1'b1);
      run(~v[0], 1, ST_ZEROS + v, 1'b1);
      run(v[0], 0, ST_ZEROS + v, 1'b0);
    end
  endtask
  // prbs, then a 20-bit repetitive length, must track error-free
  task automatic t_modes();
    logic [31:0] b0, b1, q;
    logic [23:0] e0, e1;
    logic [15:0] st;
    logic [14:0] lfsr;
    logic [19:0] rp;
    logic        nb;
    lfsr = 15'h7FFF;
    rp   = 20'hC5A93;
    for (int m = 0; m < 2; m++) begin
      ctl = (m == 0) ? 16'h2002 : 16'h2300;
      bus(1'b1, CTRL_OFS, {16'h0000, ctl}, q);
      bus(1'b0, CTRL_OFS, 32'h0, q);
      chk(q, {16'h0000, ctl});
      for (int i = 0; i < 104; i++) begin
        if (i == 64) begin
          repeat (8) @(posedge hclk);
          snap(b0, e0, st);
        end
        nb = (m == 0) ? (lfsr[13] ^ lfsr[14]) : rp[i % 20];
        lfsr = {lfsr[13:0], nb};
        u_src.send_bit(nb);
      end
      repeat (8) @(posedge hclk);
      snap(b1, e1, st);
      chk({30'h0, lock, irq}, 32'h2);
      chk(b1 - b0, 32'h28);
      chk({8'h00, e1 - e0}, 32'h0);
    end
  endtask
  // ==========================================================
  // main sequence and timeout
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hresetn = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    idx = 0;
    ctl = 16'h0000;
    pat = 17'h1A5B3;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_lock();
    t_error();
    t_loss();
    t_runs();
    t_modes();
    finish_test();
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end
endmodule // bert_receive_monitor_tb
